//--- rtl/led_addr_pkg.sv
// shared constants, types and states of the led driver i2c target front end
package led_addr_pkg;

    // ==========================================================
    // widths
    localparam int PTR_W  = 5;
    localparam int AI_W   = 3;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 7;
    localparam int NUM_SUB = 3;
    localparam int MODE_W = 5;

    // ==========================================================
    // register pointer values
    localparam logic [PTR_W-1:0] REG_MODE1      = 5'h00;
    localparam logic [PTR_W-1:0] REG_ALL_FIRST  = 5'h00;
    localparam logic [PTR_W-1:0] REG_PWM_FIRST  = 5'h02;
    localparam logic [PTR_W-1:0] REG_GRP_FIRST  = 5'h0a;
    localparam logic [PTR_W-1:0] REG_GRP_LAST   = 5'h0b;
    localparam logic [PTR_W-1:0] REG_SUB_FIRST  = 5'h0e;
    localparam logic [PTR_W-1:0] REG_GROUP_ADDR = 5'h11;
    localparam logic [PTR_W-1:0] REG_LAST       = 5'h11;

    // ==========================================================
    // reset values and fixed address bytes
    localparam logic [BYTE_W-1:0] GROUP_ADDR_RST = 8'he0;
    localparam logic [NUM_SUB-1:0][BYTE_W-1:0] SUB_ADDR_RST = {8'he8, 8'he4, 8'he2};
    localparam logic [BYTE_W-1:0] SOFT_RESET_BYTE = 8'h06;
    // sleep=1, subgroup enables=0, group call enable=1
    localparam logic [MODE_W-1:0] MODE_RST = 5'h11;
    localparam int MODE_GROUP_EN_BIT  = 0;
    localparam int MODE_SUB_FIRST_BIT = 3;
    localparam logic [PTR_W-1:0] PTR_RST = 5'h00;

    // ==========================================================
    // autoinc_field encodings
    localparam logic [AI_W-1:0] AI_OFF        = 3'h0;
    localparam logic [AI_W-1:0] AI_ALL        = 3'h4;
    localparam logic [AI_W-1:0] AI_PWM        = 3'h5;
    localparam logic [AI_W-1:0] AI_GLOBAL     = 3'h6;
    localparam logic [AI_W-1:0] AI_PWM_GLOBAL = 3'h7;
    localparam logic [AI_W-1:0] AI_RST        = 3'h4;

    // ==========================================================
    // bit counting
    localparam logic [3:0] CNT_ZERO  = 4'h0;
    localparam logic [3:0] CNT_LAST  = 4'h7;
    localparam logic [3:0] CNT_BYTE  = 4'h8;

    // ==========================================================
    // types
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_RX      = 3'b001,
        ST_ACK     = 3'b010,
        ST_TX      = 3'b011,
        ST_RACK    = 3'b100,
        ST_STRETCH = 3'b101
    } state_t;

    typedef enum logic [1:0] {
        PH_ADDR = 2'b00,
        PH_CTRL = 2'b01,
        PH_DATA = 2'b10
    } phase_t;

    typedef struct packed {
        logic [PTR_W-1:0]  addr;
        logic [BYTE_W-1:0] data;
    } wr_word_t;

endpackage : led_addr_pkg

//--- rtl/word_skid_buffer.sv
// small valid/ready buffer holding register writes until the consumer takes them
`timescale 1ns/1ps
module word_skid_buffer
    import led_addr_pkg::*;
#(
    parameter int WIDTH = 13,
    parameter int DEPTH = 2
) (
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [AW-1:0] IDX_LAST = AW'(DEPTH - 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr_idx;
        logic [AW-1:0]               rd_idx;
        logic [CW-1:0]               count;
    } buf_t;

    buf_t r;
    buf_t r_nxt;
    logic push;
    logic pop;

    // ==========================================================
    // handshakes: honest full and empty from the occupancy count
    assign in_ready_o  = (r.count != CNT_FULL);
    assign out_valid_o = (r.count != '0);
    assign out_data_o  = r.mem[r.rd_idx];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // next state
    always_comb begin
        r_nxt = r;
        if (push) begin
            r_nxt.mem[r.wr_idx] = in_data_i;
            r_nxt.wr_idx = (r.wr_idx == IDX_LAST) ? '0 : AW'(r.wr_idx + 1'b1);
        end
        if (pop) begin
            r_nxt.rd_idx = (r.rd_idx == IDX_LAST) ? '0 : AW'(r.rd_idx + 1'b1);
        end
        if (push && !pop) begin
            r_nxt.count = CW'(r.count + 1'b1);
        end else if (pop && !push) begin
            r_nxt.count = CW'(r.count - 1'b1);
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r <= '0;
        end else begin
            r <= r_nxt;
        end
    end

endmodule : word_skid_buffer

//--- rtl/led_i2c_front.sv
// i2c target front end: address decode, control byte, pointer auto-increment
`timescale 1ns/1ps
module led_i2c_front
    import led_addr_pkg::*;
#(
    parameter int BUF_DEPTH = 2
) (
    input  wire logic              clk_i,
    input  wire logic              rstn_i,
    input  wire logic              scl_i,
    output logic                   scl_o,
    output logic                   scl_oe_o,
    input  wire logic              sda_i,
    output logic                   sda_o,
    output logic                   sda_oe_o,
    input  wire logic [ADDR_W-1:0] addr_pins_i,
    output logic                   wr_valid_o,
    input  wire logic              wr_ready_i,
    output wr_word_t               wr_word_o,
    output logic [PTR_W-1:0]       rd_addr_o,
    input  wire logic [BYTE_W-1:0] rd_data_i,
    output logic [AI_W-1:0]        autoinc_field_o,
    output logic [MODE_W-1:0]      mode_bits_o,
    output logic                   soft_reset_call_o
);

    // ==========================================================
    // state
    typedef struct packed {
        state_t                        state;
        phase_t                        phase;
        logic [3:0]                    cnt;
        logic [BYTE_W-1:0]             shreg;
        logic                          scl_q;
        logic                          sda_q;
        logic                          rw;
        logic                          soft_reset_call_hit;
        logic                          rack_ok;
        logic                          sda_oe;
        logic [PTR_W-1:0]              pointer;
        logic [AI_W-1:0]               autoinc_field;
        logic [MODE_W-1:0]             mode;
        logic [NUM_SUB-1:0][BYTE_W-1:0] sub_addr;
        logic [BYTE_W-1:0]             group_call_address_reg;
        logic                          soft_reset_call;
    } core_t;

    localparam core_t CORE_RST = '{
        state:                  ST_IDLE,
        phase:                  PH_ADDR,
        cnt:                    CNT_ZERO,
        shreg:                  '0,
        scl_q:                  1'b1,
        sda_q:                  1'b1,
        rw:                     1'b0,
        soft_reset_call_hit:              1'b0,
        rack_ok:                1'b0,
        sda_oe:                 1'b0,
        pointer:                PTR_RST,
        autoinc_field:          AI_RST,
        mode:                   MODE_RST,
        sub_addr:               SUB_ADDR_RST,
        group_call_address_reg: GROUP_ADDR_RST,
        soft_reset_call:        1'b0
    };

    core_t r;
    core_t r_nxt;

    // ==========================================================
    // pointer stepping per autoinc_field
    function automatic logic [PTR_W-1:0] next_ptr(input logic [PTR_W-1:0] p,
                                                  input logic [AI_W-1:0]  ai);
        logic [PTR_W-1:0] inc;
        inc = PTR_W'(p + 1'b1);
        unique case (ai)
            AI_ALL:        next_ptr = (p == REG_LAST) ? REG_ALL_FIRST : inc;
            AI_PWM:        next_ptr = (p == REG_LAST) ? REG_PWM_FIRST : inc;
            AI_GLOBAL:     next_ptr = (p == REG_GRP_LAST) ? REG_GRP_FIRST : inc;
            AI_PWM_GLOBAL: next_ptr = (p == REG_GRP_LAST) ? REG_PWM_FIRST : inc;
            default:       next_ptr = p;  // 000 holds; reserved codes also hold
        endcase
    endfunction : next_ptr

    // ==========================================================
    // read data: locally held registers, else the outer register file
    function automatic logic [BYTE_W-1:0] read_byte(input core_t c,
                                                    input logic [BYTE_W-1:0] ext);
        read_byte = ext;
        if (c.pointer == REG_MODE1) begin
            read_byte = {c.autoinc_field, c.mode};
        end else if (c.pointer == REG_GROUP_ADDR) begin
            read_byte = c.group_call_address_reg;
        end else if (c.pointer >= REG_SUB_FIRST) begin
            read_byte = c.sub_addr[PTR_W'(c.pointer - REG_SUB_FIRST)];
        end
    endfunction : read_byte

    // next byte to shift out, taken at the falling scl edge
    logic [BYTE_W-1:0] rd_byte;
    assign rd_byte = read_byte(r, rd_data_i);

    // ==========================================================
    // address matching, one comparator per subgroup address
    logic [NUM_SUB-1:0] sub_hit;
    logic               hit_regular;
    logic               hit_group;
    logic               hit_soft_reset_call_addr;

    for (genvar i = 0; i < NUM_SUB; i++) begin : g_sub
        // mode bit 3 enables the first entry, bit 1 the third
        assign sub_hit[i] = r.mode[MODE_SUB_FIRST_BIT - i]
                            && (r.shreg[BYTE_W-1:1] == r.sub_addr[i][BYTE_W-1:1]);
    end

    assign hit_regular    = (r.shreg[BYTE_W-1:1] == addr_pins_i);
    assign hit_group      = r.mode[MODE_GROUP_EN_BIT]
                            && (r.shreg[BYTE_W-1:1]
                                == r.group_call_address_reg[BYTE_W-1:1]);
    assign hit_soft_reset_call_addr = (r.shreg[BYTE_W-1:1] == SOFT_RESET_BYTE[BYTE_W-1:1]);

    // ==========================================================
    // bus edge and condition detection on the synchronous pin samples
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    assign scl_rise   = scl_i && !r.scl_q;
    assign scl_fall   = !scl_i && r.scl_q;
    assign start_cond = scl_i && r.scl_q && r.sda_q && !sda_i;
    assign stop_cond  = scl_i && r.scl_q && !r.sda_q && sda_i;

    // ==========================================================
    // write buffer between the byte engine and the register file
    logic     buf_in_ready;
    logic     buf_in_valid;
    wr_word_t buf_in_word;

    assign buf_in_valid = (r.state == ST_STRETCH);
    assign buf_in_word  = '{addr: r.pointer, data: r.shreg};

    word_skid_buffer #(
        .WIDTH ($bits(wr_word_t)),
        .DEPTH (BUF_DEPTH)
    ) u_wr_buf (
        .clk_i       (clk_i),
        .rstn_i      (rstn_i),
        .in_valid_i  (buf_in_valid),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (buf_in_word),
        .out_valid_o (wr_valid_o),
        .out_ready_i (wr_ready_i),
        .out_data_o  (wr_word_o)
    );

    // ==========================================================
    // byte engine
    always_comb begin
        r_nxt = r;
        r_nxt.scl_q = scl_i;
        r_nxt.sda_q = sda_i;
        r_nxt.soft_reset_call = 1'b0;

        if (start_cond) begin
            // a repeated start restarts address reception in any state
            r_nxt.state  = ST_RX;
            r_nxt.phase  = PH_ADDR;
            r_nxt.cnt    = CNT_ZERO;
            r_nxt.sda_oe = 1'b0;
        end else if (stop_cond) begin
            r_nxt.state  = ST_IDLE;
            r_nxt.sda_oe = 1'b0;
        end else begin
            unique case (r.state)
                ST_IDLE: begin
                    r_nxt.sda_oe = 1'b0;
                end

                ST_RX: begin
                    if (scl_rise && r.cnt != CNT_BYTE) begin
                        r_nxt.shreg = {r.shreg[BYTE_W-2:0], sda_i};
                        r_nxt.cnt   = 4'(r.cnt + 1'b1);
                    end else if (scl_fall && r.cnt == CNT_BYTE) begin
                        unique case (r.phase)
                            PH_ADDR: begin
                                r_nxt.rw        = r.shreg[0];
                                r_nxt.soft_reset_call_hit = 1'b0;
                                if (hit_soft_reset_call_addr) begin
                                    // write only; a read of this byte is left unanswered
                                    if (!r.shreg[0]) begin
                                        r_nxt.soft_reset_call_hit       = 1'b1;
                                        r_nxt.soft_reset_call = 1'b1;
                                        r_nxt.state           = ST_ACK;
                                        r_nxt.sda_oe          = 1'b1;
                                    end else begin
                                        r_nxt.state = ST_IDLE;
                                    end
                                end else if (hit_regular || hit_group || (|sub_hit)) begin
                                    r_nxt.state  = ST_ACK;
                                    r_nxt.sda_oe = 1'b1;
                                    r_nxt.phase  = PH_CTRL;
                                end else begin
                                    r_nxt.state = ST_IDLE;
                                end
                            end
                            PH_CTRL: begin
                                if (r.shreg[PTR_W-1:0] <= REG_LAST) begin
                                    r_nxt.pointer       = r.shreg[PTR_W-1:0];
                                    r_nxt.autoinc_field = r.shreg[BYTE_W-1:PTR_W];
                                    r_nxt.phase         = PH_DATA;
                                    r_nxt.state         = ST_ACK;
                                    r_nxt.sda_oe        = 1'b1;
                                end else begin
                                    r_nxt.state = ST_IDLE;
                                end
                            end
                            PH_DATA: begin
                                // hold scl low until the buffer takes the word
                                r_nxt.state = ST_STRETCH;
                            end
                            default: begin
                                r_nxt.state = ST_IDLE;
                            end
                        endcase
                    end
                end

                ST_STRETCH: begin
                    if (buf_in_ready) begin
                        if (r.pointer == REG_MODE1) begin
                            // autoinc field bits read back only
                            r_nxt.mode = r.shreg[MODE_W-1:0];
                        end else if (r.pointer == REG_GROUP_ADDR) begin
                            r_nxt.group_call_address_reg = r.shreg;
                        end else if (r.pointer >= REG_SUB_FIRST) begin
                            r_nxt.sub_addr[PTR_W'(r.pointer - REG_SUB_FIRST)] = r.shreg;
                        end
                        // only the pointer moves
                        r_nxt.pointer = next_ptr(r.pointer, r.autoinc_field);
                        r_nxt.state   = ST_ACK;
                        r_nxt.sda_oe  = 1'b1;
                    end
                end

                ST_ACK: begin
                    if (scl_fall) begin
                        r_nxt.sda_oe = 1'b0;
                        r_nxt.cnt    = CNT_ZERO;
                        if (r.soft_reset_call_hit) begin
                            r_nxt.state = ST_IDLE;
                        end else if (r.rw) begin
                            r_nxt.shreg  = rd_byte;
                            r_nxt.sda_oe = !rd_byte[BYTE_W-1];
                            r_nxt.state  = ST_TX;
                        end else begin
                            r_nxt.state = ST_RX;
                        end
                    end
                end

                ST_TX: begin
                    if (scl_fall) begin
                        if (r.cnt == CNT_LAST) begin
                            r_nxt.sda_oe = 1'b0;   // release for the controller's ack
                            r_nxt.state  = ST_RACK;
                        end else begin
                            r_nxt.shreg  = {r.shreg[BYTE_W-2:0], 1'b0};
                            r_nxt.sda_oe = !r.shreg[BYTE_W-2];
                            r_nxt.cnt    = 4'(r.cnt + 1'b1);
                        end
                    end
                end

                ST_RACK: begin
                    if (scl_rise) begin
                        r_nxt.rack_ok = !sda_i;
                        r_nxt.pointer = next_ptr(r.pointer, r.autoinc_field);
                    end else if (scl_fall) begin
                        r_nxt.cnt = CNT_ZERO;
                        if (r.rack_ok) begin
                            r_nxt.shreg  = rd_byte;
                            r_nxt.sda_oe = !rd_byte[BYTE_W-1];
                            r_nxt.state  = ST_TX;
                        end else begin
                            r_nxt.state = ST_IDLE;
                        end
                    end
                end

                default: begin
                    r_nxt.state  = ST_IDLE;
                    r_nxt.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r <= CORE_RST;
        end else begin
            r <= r_nxt;
        end
    end

    // ==========================================================
    // outputs; both pins are open drain and only ever pull low
    assign scl_o             = 1'b0;
    assign scl_oe_o          = (r.state == ST_STRETCH);
    assign sda_o             = 1'b0;
    assign sda_oe_o          = r.sda_oe;
    assign rd_addr_o         = r.pointer;
    assign autoinc_field_o   = r.autoinc_field;
    assign mode_bits_o       = r.mode;
    assign soft_reset_call_o = r.soft_reset_call;

endmodule : led_i2c_front

//--- bench/led_i2c_front_sva.sv
// concurrent checks on the ports of the led i2c front end
`timescale 1ns/1ps
module led_i2c_front_sva
    import led_addr_pkg::*;
(
    input wire logic             clk_i,
    input wire logic             rstn_i,
    input wire logic             scl_oe_o,
    input wire logic             sda_oe_o,
    input wire logic             wr_valid_o,
    input wire logic [PTR_W-1:0] rd_addr_o,
    input wire logic [AI_W-1:0]  autoinc_field_o,
    input wire logic             soft_reset_call_o
);
    // ==========================================================
    // pointer steps land as the stretch of a data byte ends
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);
    a_ptr_fixed: assert property ($fell(scl_oe_o) && autoinc_field_o == 3'h0
        |-> $stable(rd_addr_o)) else $error("pointer moved");
    a_ptr_step: assert property ($fell(scl_oe_o) && autoinc_field_o[2]
        && !($past(rd_addr_o) inside {5'h0b, 5'h11})
        |-> rd_addr_o == $past(rd_addr_o) + 5'h01) else $error("no step");
    a_wrap_all: assert property ($fell(scl_oe_o) && autoinc_field_o == 3'h4
        && $past(rd_addr_o) == 5'h11 |-> rd_addr_o == 5'h00) else $error("no wrap 00");
    a_wrap_pwm: assert property ($fell(scl_oe_o) && autoinc_field_o == 3'h5
        && $past(rd_addr_o) == 5'h11 |-> rd_addr_o == 5'h02) else $error("no wrap 02");
    a_wrap_grp: assert property ($fell(scl_oe_o) && autoinc_field_o == 3'h6
        && $past(rd_addr_o) == 5'h0b |-> rd_addr_o == 5'h0a) else $error("no wrap 0a");
    a_wrap_mix: assert property ($fell(scl_oe_o) && autoinc_field_o == 3'h7
        && $past(rd_addr_o) == 5'h0b |-> rd_addr_o == 5'h02) else $error("no wrap 02");
    // the field stays put while the pointer moves
    a_ai_hold: assert property (scl_oe_o |=> $stable(autoinc_field_o))
        else $error("field changed");
    // an empty buffer takes the byte after a one clock stretch
    a_stretch_short: assert property ($rose(scl_oe_o) && !wr_valid_o
        |=> !scl_oe_o && sda_oe_o && wr_valid_o) else $error("stretch too long");
    a_soft_reset_call_pulse: assert property (soft_reset_call_o
        |=> !soft_reset_call_o && (sda_oe_o || $past(sda_oe_o))) else $error("bad pulse");
    // main scenarios seen
    c_wrap: cover property ($fell(scl_oe_o) && rd_addr_o == 5'h02);
    c_soft_reset_call: cover property (soft_reset_call_o);
    c_stall: cover property ($rose(scl_oe_o) && wr_valid_o);
endmodule : led_i2c_front_sva

//--- bench/i2c_ctl.sv
// bus controller model driving open-drain scl and sda
`timescale 1ns/1ps
module i2c_ctl (
    input  wire logic clk_i,
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o
);
    // ==========================================================
    // released lines float high through the pull-ups
    logic hung = 1'b0;
    initial {scl_o, sda_o} = 2'b11;
    task automatic gap(input int n);
        repeat (n) @(negedge clk_i);
    endtask : gap
    // one bit, 1 releases sda; a stretch is waited out, bounded
    task automatic bit_x(input logic b, output logic s);
        int k;
        scl_o = 1'b0;
        gap(4);
        sda_o = b;
        gap(4);
        scl_o = 1'b1;
        for (k = 0; k < 1000 && scl_i !== 1'b1; k++) gap(1);
        hung |= (k == 1000);
        gap(4);
        s = sda_i;
    endtask : bit_x
    // msb first, then the ninth bit; ack is sda low
    task automatic byte_x(input logic [7:0] d, input logic ai, output logic [7:0] q,
                          output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], s);
            q[i] = s;
        end
        bit_x(ai, s);
        ack = !s;
    endtask : byte_x
    // start and stop: sda moves while scl is high
    task automatic start();
        {scl_o, sda_o} = 2'b11;
        gap(4);
        sda_o = 1'b0;
        gap(4);
    endtask : start
    task automatic stop();
        scl_o = 1'b0;
        gap(4);
        sda_o = 1'b0;
        gap(4);
        scl_o = 1'b1;
        gap(4);
        sda_o = 1'b1;
        gap(8);
    endtask : stop
endmodule : i2c_ctl

//--- bench/led_i2c_front_tb.sv
// self-checking bench for the led i2c front end
`timescale 1ns/1ps
module led_i2c_front_tb;
    import led_addr_pkg::*;
    // ==========================================================
    logic              clk_i = 1'b0;
    logic              rstn_i = 1'b0;
    logic              wr_ready_i = 1'b1;
    logic              scl_m, sda_m, scl_o, sda_o, scl_oe_o, sda_oe_o, wr_valid_o, sr_o;
    wr_word_t          wr_word_o;
    wr_word_t          q[$];
    logic [PTR_W-1:0]  rd_addr_o, p = 5'h00;
    logic [AI_W-1:0]   autoinc_field_o, ai = 3'h4;
    logic [MODE_W-1:0] mode_bits_o;
    int                error_cnt = 0, checks = 0, sr_cnt = 0;
    // rows: address, control, count, first data, address ack; no reserved field codes
    logic [31:0] rows [21] = '{32'h54853a01, 32'h54912e01, 32'he0b12e01, 32'h54cb3101,
        32'h54eb2201, 32'h55002001, 32'he1001001, 32'h54121001, 32'h56000000, 32'h06000001,
        32'h07000000, 32'he2000000, 32'he5000000, 32'he9000000, 32'h540010e1, 32'he2000001,
        32'he4000001, 32'he8000001, 32'he0000000, 32'he8001111, 32'he0000001};
    // open-drain lines are low while either side pulls
    wire scl_w = scl_m & (scl_oe_o ? scl_o : 1'b1);
    wire sda_w = sda_m & (sda_oe_o ? sda_o : 1'b1);
    initial forever #20 clk_i = ~clk_i;
    // consumer of the write buffer
    always @(posedge clk_i) if (wr_valid_o && wr_ready_i) q.push_back(wr_word_o);
    // soft reset pulses seen over the whole run
    always @(posedge clk_i) if (sr_o === 1'b1) sr_cnt++;
    i2c_ctl i2c_ctl_inst (.clk_i(clk_i), .scl_i(scl_w), .sda_i(sda_w), .scl_o(scl_m),
        .sda_o(sda_m));
    led_i2c_front led_i2c_front_inst (.clk_i(clk_i), .rstn_i(rstn_i), .scl_i(scl_w),
        .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
        .addr_pins_i(7'h2a), .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i),
        .wr_word_o(wr_word_o), .rd_addr_o(rd_addr_o), .rd_data_i({3'h0, rd_addr_o}),
        .autoinc_field_o(autoinc_field_o), .mode_bits_o(mode_bits_o), .soft_reset_call_o(sr_o));
    task automatic chk(input string nm, input logic [15:0] s, e);
        checks++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // expected pointer after one data byte
    function automatic logic [4:0] nxt(input logic [4:0] a, input logic [2:0] m);
        case (m)
            3'h4: return (a == 5'h11) ? 5'h00 : a + 5'h01;
            3'h5: return (a == 5'h11) ? 5'h02 : a + 5'h01;
            3'h6: return (a == 5'h0b) ? 5'h0a : a + 5'h01;
            3'h7: return (a == 5'h0b) ? 5'h02 : a + 5'h01;
            default: return a;
        endcase
    endfunction : nxt
    // one transaction: address, then control and data, or read data
    task automatic run_row(input logic [31:0] r);
        logic [7:0] a, c, d, x;
        logic [3:0] n, k;
        logic       ak;
        {a, c, n, d, k} = r;
        q.delete();
        i2c_ctl_inst.start();
        i2c_ctl_inst.byte_x(a, 1'b1, x, ak);
        chk("address ack", ak, k[0]);
        if (ak && !a[0] && n != 0) begin
            i2c_ctl_inst.byte_x(c, 1'b1, x, ak);
            chk("control ack", ak, c[4:0] <= 5'h11);
            for (int i = 0; i < n && ak; i++) i2c_ctl_inst.byte_x(d + 8'(i), 1'b1, x, ak);
        end
        for (int i = 0; i < n && ak && a[0]; i++) begin
            i2c_ctl_inst.byte_x(8'hff, i == n - 1, x, ak);
            chk("read data", x, {3'h0, p});
            p = nxt(p, ai);
        end
        i2c_ctl_inst.stop();
        if (ak && !a[0] && n != 0) begin
            {p, ai} = {c[4:0], c[7:5]};
            chk("word count", q.size(), n);
            chk("autoinc field", autoinc_field_o, ai);
            foreach (q[i]) begin
                chk("word", q[i], {p, d + 8'(i)});
                p = nxt(p, ai);
            end
        end
    endtask : run_row
    task automatic print_verdict();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict
    // watchdog sized well above the expected run
    initial begin
        repeat (40000) @(posedge clk_i);
        error_cnt++;
        print_verdict();
    end
    initial begin
        repeat (2) @(negedge clk_i);
        rstn_i = 1'b1;
        repeat (2) @(negedge clk_i);
        foreach (rows[i]) begin
            run_row(rows[i]);
            $display("row %0d done", i);
        end
        // consumer stalls: buffer fills and scl is held low meanwhile
        wr_ready_i = 1'b0;
        fork
            begin
                repeat (800) @(negedge clk_i);
                wr_ready_i = 1'b1;
            end
            run_row(32'h54864301);
        join
        $display("stall test done");
        // reset in mid-run after enabling subgroups
        run_row(32'h540010e1);
        run_row(32'h540e1e61);
        run_row(32'he6000001);
        rstn_i = 1'b0;
        repeat (2) @(negedge clk_i);
        chk("pointer reset", rd_addr_o, 5'h00);
        chk("mode reset", mode_bits_o, 5'h11);
        chk("field reset", autoinc_field_o, 3'h4);
        rstn_i = 1'b1;
        repeat (2) @(negedge clk_i);
        run_row(32'he2000000);
        run_row(32'he0000001);
        $display("reset test done");
        chk("bus hang", i2c_ctl_inst.hung, 1'b0);
        chk("soft reset calls", sr_cnt, 1);
        print_verdict();
    end
endmodule : led_i2c_front_tb
bind led_i2c_front led_i2c_front_sva led_i2c_front_sva_inst (.clk_i(clk_i), .rstn_i(rstn_i),
    .scl_oe_o(scl_oe_o), .sda_oe_o(sda_oe_o), .wr_valid_o(wr_valid_o), .rd_addr_o(rd_addr_o),
    .autoinc_field_o(autoinc_field_o), .soft_reset_call_o(soft_reset_call_o));
